// File: rtl/pci_cycle_pkg.sv
// Constants and types shared by the PCI cycle controller
package pci_cycle_pkg;
    localparam logic [3:0] CMD_MEM_RD_MULT = 4'hc;
    localparam logic [3:0] CMD_MEM_RD_LINE = 4'he;
    localparam logic [3:0] CMD_MEM_WR      = 4'h7;
    localparam logic [3:0] CMD_MEM_WR_INV  = 4'hf;
    localparam int STS_DET_PERR_BIT   = 15;
    localparam int STS_SIG_SERR_BIT   = 14;
    localparam int STS_RCV_TABORT_BIT = 12;
    localparam int STS_DATA_PERR_BIT  = 8;
    localparam int CMD_SERR_EN_BIT    = 8;
    localparam int CMD_PERR_RESP_BIT  = 6;
    localparam logic [2:0] MABORT_CLKS   = 3'h5;
    localparam logic [15:0] NO_LIMIT     = 16'hffff;
    localparam logic [31:0] WORD_BYTES   = 32'h0000_0004;
    localparam logic [1:0] DONE_OK       = 2'h0;
    localparam logic [1:0] DONE_TABORT   = 2'h1;
    localparam logic [1:0] DONE_MABORT   = 2'h2;
    typedef enum logic [1:0] {KIND_TX_RD, KIND_CTRL_RD, KIND_CTRL_WR, KIND_RX_WR} job_kind_t;
    typedef enum logic [2:0] {T_IDLE, T_RETRY, T_WAIT, T_DATA, T_HOLD, T_TURN} tgt_state_t;
    typedef enum logic [2:0] {M_IDLE, M_REQ, M_ADDR, M_DATA, M_LAST, M_TURN} mst_state_t;
endpackage : pci_cycle_pkg

// File: rtl/two_entry_buffer.sv
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module two_entry_buffer
    import pci_cycle_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        in_valid,
    output logic             in_ready,
    input  wire logic [31:0] in_data,
    output logic             out_valid,
    input  wire logic        out_ready,
    output logic [31:0]      out_data,
    output logic [1:0]       level
);
    logic [31:0] mem_reg [2];
    logic [31:0] mem_next [2];
    logic        wp_reg, wp_next, rp_reg, rp_next;
    logic [1:0]  cnt_reg, cnt_next;
    logic        push, pop;

    assign in_ready  = (cnt_reg != 2'h2);
    assign out_valid = (cnt_reg != 2'h0);
    assign out_data  = mem_reg[rp_reg];
    assign level     = cnt_reg;
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        mem_next = mem_reg;
        wp_next  = wp_reg ^ push;
        rp_next  = rp_reg ^ pop;
        cnt_next = cnt_reg + {1'b0, push} - {1'b0, pop};
        if (push) begin
            mem_next[wp_reg] = in_data;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mem_reg[0] <= 32'h0;
            mem_reg[1] <= 32'h0;
            wp_reg     <= 1'b0;
            rp_reg     <= 1'b0;
            cnt_reg    <= 2'h0;
        end else begin
            mem_reg <= mem_next;
            wp_reg  <= wp_next;
            rp_reg  <= rp_next;
            cnt_reg <= cnt_next;
        end
    end
endmodule : two_entry_buffer

// File: rtl/pci_cycle_ctrl.sv
// PCI target termination, parity error handling and bus master cycles
`timescale 1ns/1ps
module pci_cycle_ctrl
    import pci_cycle_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        frame_n_in,
    input  wire logic        irdy_n_in,
    input  wire logic        trdy_n_in,
    input  wire logic        stop_n_in,
    input  wire logic        devsel_n_in,
    input  wire logic [31:0] ad_in,
    input  wire logic [3:0]  cbe_n_in,
    input  wire logic        par_in,
    input  wire logic        gnt_n,
    output logic             req_n,
    output logic             frame_n_out,
    output logic             irdy_n_out,
    output logic [3:0]       cbe_n_out,
    output logic             m_ctl_oe_n,
    output logic             trdy_n_out,
    output logic             stop_n_out,
    output logic             devsel_n_out,
    output logic             t_ctl_oe_n,
    output logic [31:0]      ad_out,
    output logic             ad_oe_n,
    output logic             par_out,
    output logic             par_oe_n,
    output logic             perr_n_out,
    output logic             perr_oe_n,
    output logic             serr_n_out,
    output logic             serr_oe_n,
    input  wire logic        hit_cfg,
    input  wire logic        hit_csr,
    input  wire logic        hit_flash,
    input  wire logic        eeprom_load_done,
    input  wire logic        tgt_ready,
    input  wire logic [31:0] tgt_rdata,
    output logic [31:0]      tgt_addr,
    output logic [3:0]       tgt_cmd,
    output logic [31:0]      tgt_wdata,
    output logic             tgt_access,
    input  wire logic [15:0] cmd_reg,
    input  wire logic [15:0] status_clr,
    output logic [15:0]      status,
    input  wire logic [7:0]  lat_timer,
    input  wire logic        mreq_valid,
    output logic             mreq_ready,
    input  wire job_kind_t   mreq_kind,
    input  wire logic [31:0] mreq_addr,
    input  wire logic [15:0] mreq_words,
    input  wire logic        mwi_ok,
    input  wire logic [15:0] tx_space_words,
    input  wire logic [15:0] rx_avail_words,
    input  wire logic [15:0] tx_max_bytes,
    input  wire logic [15:0] rx_max_bytes,
    input  wire logic [31:0] wr_data,
    output logic             wr_ready,
    output logic             rd_valid,
    input  wire logic        rd_ready,
    output logic [31:0]      rd_data,
    output logic             mdone,
    output logic [1:0]       mdone_code,
    output logic             mdone_perr
);
    function automatic logic [15:0] min16(input logic [15:0] a, input logic [15:0] b);
        min16 = (a < b) ? a : b;
    endfunction : min16

    function automatic logic [15:0] byte_lim(input logic [15:0] bytes);
        byte_lim = (bytes == 16'h0) ? NO_LIMIT : ((bytes[15:2] == 14'h0) ? 16'h1 :
                   {2'b00, bytes[15:2]});
    endfunction : byte_lim

    // Target side
    tgt_state_t  t_state, t_state_next;
    logic [31:0] t_addr_reg, t_addr_next, t_rdata_reg, t_rdata_next;
    logic [31:0] t_wdata_reg, t_wdata_next;
    logic [3:0]  t_cmd_reg, t_cmd_next;
    logic        frame_q, addr_phase, t_read;

    assign addr_phase = !frame_n_in && frame_q && irdy_n_in;
    assign t_read     = !t_cmd_reg[0];

    always_comb begin
        t_state_next = t_state;
        t_addr_next  = t_addr_reg;
        t_cmd_next   = t_cmd_reg;
        t_rdata_next = t_rdata_reg;
        t_wdata_next = t_wdata_reg;
        case (t_state)
            T_IDLE: begin
                if (addr_phase && (hit_cfg || hit_csr || hit_flash)) begin
                    t_addr_next = ad_in;
                    t_cmd_next  = cbe_n_in;
                    if (hit_cfg && !eeprom_load_done) begin
                        t_state_next = T_RETRY;
                    end else begin
                        t_state_next = T_WAIT;
                    end
                end
            end
            T_RETRY: begin
                if (frame_n_in) begin
                    t_state_next = T_TURN;
                end
            end
            T_WAIT: begin
                if (tgt_ready && !irdy_n_in) begin
                    t_rdata_next = tgt_rdata;
                    t_state_next = T_DATA;
                end
            end
            T_DATA: begin
                t_wdata_next = ad_in;
                t_state_next = frame_n_in ? T_TURN : T_HOLD;
            end
            T_HOLD: begin
                if (frame_n_in) begin
                    t_state_next = T_TURN;
                end
            end
            T_TURN: t_state_next = T_IDLE;
            default: t_state_next = T_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            t_state     <= T_IDLE;
            t_addr_reg  <= 32'h0;
            t_cmd_reg   <= 4'h0;
            t_rdata_reg <= 32'h0;
            t_wdata_reg <= 32'h0;
            frame_q     <= 1'b1;
        end else begin
            t_state     <= t_state_next;
            t_addr_reg  <= t_addr_next;
            t_cmd_reg   <= t_cmd_next;
            t_rdata_reg <= t_rdata_next;
            t_wdata_reg <= t_wdata_next;
            frame_q     <= frame_n_in;
        end
    end

    assign t_ctl_oe_n   = (t_state == T_IDLE);
    assign devsel_n_out = (t_state == T_IDLE) || (t_state == T_TURN);
    assign trdy_n_out   = (t_state != T_DATA);
    assign stop_n_out   = !((t_state == T_RETRY) || (t_state == T_DATA) ||
                            (t_state == T_HOLD));
    assign tgt_addr     = t_addr_reg;
    assign tgt_cmd      = t_cmd_reg;
    assign tgt_wdata    = t_wdata_reg;
    assign tgt_access   = (t_state == T_DATA);

    // Master side
    mst_state_t  m_state, m_state_next;
    job_kind_t   kind_reg, kind_next;
    logic        job_reg, job_next, wd_reg, wd_next;
    logic [31:0] addr_reg, addr_next, wdata_reg, wdata_next;
    logic [15:0] words_reg, words_next, burst_reg, burst_next, lim;
    logic [7:0]  lat_reg, lat_next;
    logic [2:0]  dw_reg, dw_next;
    logic        done_reg, done_next, perr_job_reg, perr_job_next;
    logic [1:0]  code_reg, code_next;
    logic        is_rd, xfer, backoff, in_data, rd_push, buf_room, m_data_err;
    logic [1:0]  buf_level;
    logic [3:0]  m_cmd;

    assign is_rd   = (kind_reg == KIND_TX_RD) || (kind_reg == KIND_CTRL_RD);
    assign in_data = (m_state == M_DATA) || (m_state == M_LAST);
    assign xfer    = in_data && !trdy_n_in;
    assign backoff = (lat_reg >= lat_timer) && gnt_n;
    assign rd_push = xfer && is_rd;
    assign buf_room = (buf_level == 2'h0) || (rd_ready && buf_level == 2'h1);

    always_comb begin
        case (kind_reg)
            KIND_TX_RD:   m_cmd = CMD_MEM_RD_MULT;
            KIND_CTRL_RD: m_cmd = CMD_MEM_RD_LINE;
            KIND_CTRL_WR: m_cmd = CMD_MEM_WR;
            default:      m_cmd = mwi_ok ? CMD_MEM_WR_INV : CMD_MEM_WR;
        endcase
        case (kind_reg)
            KIND_TX_RD: lim = min16(words_reg, min16(tx_space_words,
                                    byte_lim(tx_max_bytes)));
            KIND_RX_WR: lim = min16(words_reg, min16(rx_avail_words,
                                    byte_lim(rx_max_bytes)));
            default:    lim = words_reg;
        endcase
    end

    always_comb begin
        m_state_next  = m_state;
        kind_next     = kind_reg;
        job_next      = job_reg;
        addr_next     = addr_reg;
        words_next    = words_reg;
        burst_next    = burst_reg;
        wdata_next    = wdata_reg;
        wd_next       = wd_reg;
        lat_next      = lat_reg;
        dw_next       = dw_reg;
        done_next     = 1'b0;
        code_next     = code_reg;
        perr_job_next = perr_job_reg || m_data_err;
        wr_ready      = 1'b0;
        case (m_state)
            M_IDLE: begin
                if (mreq_valid) begin
                    kind_next     = mreq_kind;
                    addr_next     = mreq_addr;
                    words_next    = mreq_words;
                    job_next      = (mreq_words != 16'h0);
                    perr_job_next = 1'b0;
                    wd_next       = 1'b0;
                    m_state_next  = (mreq_words != 16'h0) ? M_REQ : M_IDLE;
                end
            end
            M_REQ: begin
                if (!gnt_n && frame_n_in && irdy_n_in && lim != 16'h0 &&
                    (!is_rd || buf_level != 2'h2)) begin
                    burst_next   = lim;
                    lat_next     = 8'h0;
                    dw_next      = 3'h0;
                    m_state_next = M_ADDR;
                    if (!is_rd && !wd_reg) begin
                        wr_ready   = 1'b1;
                        wdata_next = wr_data;
                        wd_next    = 1'b1;
                    end
                end
            end
            M_ADDR: begin
                m_state_next = (burst_reg == 16'h1 || (is_rd && buf_level != 2'h0))
                               ? M_LAST : M_DATA;
            end
            M_DATA, M_LAST: begin
                lat_next = (lat_reg == 8'hff) ? lat_reg : lat_reg + 8'h1;
                dw_next  = (dw_reg == MABORT_CLKS) ? dw_reg : dw_reg + 3'h1;
                if (xfer) begin
                    addr_next  = addr_reg + WORD_BYTES;
                    words_next = words_reg - 16'h1;
                    burst_next = burst_reg - 16'h1;
                    wd_next    = 1'b0;
                    if (!is_rd && m_state == M_DATA) begin
                        wr_ready   = 1'b1;
                        wdata_next = wr_data;
                        wd_next    = 1'b1;
                    end
                end
                if (!stop_n_in && devsel_n_in) begin
                    m_state_next = M_TURN;
                    job_next     = 1'b0;
                    code_next    = DONE_TABORT;
                end else if (devsel_n_in && dw_reg == MABORT_CLKS) begin
                    m_state_next = (m_state == M_DATA) ? M_LAST : M_TURN;
                    if (m_state == M_LAST) begin
                        job_next  = 1'b0;
                        code_next = DONE_MABORT;
                    end
                end else if (m_state == M_LAST) begin
                    if (xfer || !stop_n_in) begin
                        m_state_next = M_TURN;
                        job_next     = (words_next != 16'h0);
                        code_next    = DONE_OK;
                    end
                end else if (!stop_n_in || backoff) begin
                    m_state_next = M_LAST;
                end else if (xfer && (burst_reg == 16'h2 || (is_rd && !buf_room))) begin
                    m_state_next = M_LAST;
                end
            end
            M_TURN: begin
                m_state_next = job_reg ? M_REQ : M_IDLE;
                done_next    = !job_reg;
            end
            default: m_state_next = M_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            m_state      <= M_IDLE;
            kind_reg     <= KIND_TX_RD;
            job_reg      <= 1'b0;
            addr_reg     <= 32'h0;
            words_reg    <= 16'h0;
            burst_reg    <= 16'h0;
            wdata_reg    <= 32'h0;
            wd_reg       <= 1'b0;
            lat_reg      <= 8'h0;
            dw_reg       <= 3'h0;
            done_reg     <= 1'b0;
            code_reg     <= DONE_OK;
            perr_job_reg <= 1'b0;
        end else begin
            m_state      <= m_state_next;
            kind_reg     <= kind_next;
            job_reg      <= job_next;
            addr_reg     <= addr_next;
            words_reg    <= words_next;
            burst_reg    <= burst_next;
            wdata_reg    <= wdata_next;
            wd_reg       <= wd_next;
            lat_reg      <= lat_next;
            dw_reg       <= dw_next;
            done_reg     <= done_next;
            code_reg     <= code_next;
            perr_job_reg <= perr_job_next;
        end
    end

    assign mreq_ready  = (m_state == M_IDLE);
    assign req_n       = (m_state != M_REQ) || (lim == 16'h0);
    assign m_ctl_oe_n  = (m_state == M_IDLE) || (m_state == M_REQ);
    assign frame_n_out = !((m_state == M_ADDR) || (m_state == M_DATA));
    assign irdy_n_out  = !in_data;
    assign cbe_n_out   = (m_state == M_ADDR) ? m_cmd : 4'h0;
    assign mdone       = done_reg;
    assign mdone_code  = code_reg;
    assign mdone_perr  = perr_job_reg;

    always_comb begin
        if (m_state == M_ADDR) begin
            ad_out = addr_reg;
        end else if (in_data) begin
            ad_out = wdata_reg;
        end else begin
            ad_out = t_rdata_reg;
        end
    end
    assign ad_oe_n = !((m_state == M_ADDR) || (in_data && !is_rd) ||
                       (t_state == T_DATA && t_read));

    two_entry_buffer u_rd_buf (
        .clk       (clk),
        .rst       (rst),
        .in_valid  (rd_push),
        .in_ready  (),
        .in_data   (ad_in),
        .out_valid (rd_valid),
        .out_ready (rd_ready),
        .out_data  (rd_data),
        .level     (buf_level)
    );

    // Parity generation, checking and status
    logic [31:0] ad_q;
    logic [3:0]  cbe_q;
    logic        par_reg, par_oe_n_reg, chk_addr_q, chk_tdata_q, chk_mdata_q;
    logic        chk_addr_next, chk_tdata_next, chk_mdata_next;
    logic        par_bad, a_err, t_err;
    logic [1:0]  perr_cnt_reg, perr_cnt_next;
    logic        serr_reg, serr_next;
    logic [15:0] sts_reg, sts_next;
    logic        perr_resp, serr_en;

    assign perr_resp  = cmd_reg[CMD_PERR_RESP_BIT];
    assign serr_en    = cmd_reg[CMD_SERR_EN_BIT];
    assign par_bad    = par_in ^ (^{ad_q, cbe_q});
    assign a_err      = chk_addr_q && par_bad;
    assign t_err      = chk_tdata_q && par_bad;
    assign m_data_err = chk_mdata_q && par_bad;

    always_comb begin
        chk_addr_next  = addr_phase;
        chk_tdata_next = (t_state == T_DATA) && !t_read;
        chk_mdata_next = rd_push;
        sts_next       = sts_reg & ~status_clr;
        perr_cnt_next  = (perr_cnt_reg == 2'h0) ? 2'h0 : perr_cnt_reg - 2'h1;
        serr_next      = 1'b0;
        if (t_err || m_data_err || a_err) begin
            sts_next[STS_DET_PERR_BIT] = 1'b1;
        end
        if ((t_err || m_data_err) && perr_resp) begin
            perr_cnt_next = 2'h2;
        end
        if (m_data_err && perr_resp) begin
            sts_next[STS_DATA_PERR_BIT] = 1'b1;
        end
        if (a_err && serr_en && perr_resp) begin
            sts_next[STS_SIG_SERR_BIT] = 1'b1;
            serr_next                  = 1'b1;
        end
        if (!stop_n_in && devsel_n_in && in_data) begin
            sts_next[STS_RCV_TABORT_BIT] = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ad_q         <= 32'h0;
            cbe_q        <= 4'h0;
            par_reg      <= 1'b0;
            par_oe_n_reg <= 1'b1;
            chk_addr_q   <= 1'b0;
            chk_tdata_q  <= 1'b0;
            chk_mdata_q  <= 1'b0;
            perr_cnt_reg <= 2'h0;
            serr_reg     <= 1'b0;
            sts_reg      <= 16'h0;
        end else begin
            ad_q         <= ad_in;
            cbe_q        <= cbe_n_in;
            par_reg      <= ^{ad_in, cbe_n_in};
            par_oe_n_reg <= ad_oe_n;
            chk_addr_q   <= chk_addr_next;
            chk_tdata_q  <= chk_tdata_next;
            chk_mdata_q  <= chk_mdata_next;
            perr_cnt_reg <= perr_cnt_next;
            serr_reg     <= serr_next;
            sts_reg      <= sts_next;
        end
    end

    assign par_out    = par_reg;
    assign par_oe_n   = par_oe_n_reg;
    assign perr_n_out = (perr_cnt_reg != 2'h2);
    assign perr_oe_n  = (perr_cnt_reg == 2'h0);
    assign serr_n_out = 1'b0;
    assign serr_oe_n  = !serr_reg;
    assign status     = sts_reg;
endmodule : pci_cycle_ctrl

// File: verification/pci_cycle_chk_sva.sv
// Assertions on the PCI cycle controller ports
`timescale 1ns/1ps
module pci_cycle_chk
    import pci_cycle_pkg::*;
(
    input wire logic clk, rst, eeprom_load_done, t_ctl_oe_n, trdy_n_out, stop_n_out,
    input wire logic serr_oe_n, perr_oe_n, perr_n_out, m_ctl_oe_n, irdy_n_out,
    input wire logic trdy_n_in, stop_n_in, devsel_n_in, mdone,
    input wire logic [15:0] status, cmd_reg,
    input wire logic [1:0] mdone_code
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    property p_retry; !eeprom_load_done && !t_ctl_oe_n |-> trdy_n_out; endproperty
    a_retry: assert property (p_retry) else $error("trdy before load");
    property p_disc; !t_ctl_oe_n && !trdy_n_out |-> !stop_n_out ##1 trdy_n_out; endproperty
    a_disc: assert property (p_disc) else $error("target burst");
    property p_serr1; !serr_oe_n |=> serr_oe_n; endproperty
    a_serr1: assert property (p_serr1) else $error("serr width");
    property p_serr_en; !serr_oe_n |-> cmd_reg[CMD_SERR_EN_BIT] && cmd_reg[CMD_PERR_RESP_BIT];
    endproperty
    a_serr_en: assert property (p_serr_en) else $error("serr disabled");
    property p_serr_sts;
        $fell(serr_oe_n) |-> ##[0:2] status[STS_SIG_SERR_BIT] && status[STS_DET_PERR_BIT];
    endproperty
    a_serr_sts: assert property (p_serr_sts) else $error("serr flags");
    property p_perr_en; !perr_oe_n && !perr_n_out |-> cmd_reg[CMD_PERR_RESP_BIT]; endproperty
    a_perr_en: assert property (p_perr_en) else $error("perr disabled");
    property p_nowait;
        !m_ctl_oe_n && !irdy_n_out && !devsel_n_in && trdy_n_in && stop_n_in |=> !irdy_n_out;
    endproperty
    a_nowait: assert property (p_nowait) else $error("irdy wait");
    property p_tabort; mdone && mdone_code == DONE_TABORT |-> status[STS_RCV_TABORT_BIT];
    endproperty
    a_tabort: assert property (p_tabort) else $error("abort flag");
endmodule : pci_cycle_chk
bind pci_cycle_ctrl pci_cycle_chk u_chk (.*);

// File: verification/pci_mem_model.sv
// Memory target model facing the master side
`timescale 1ns/1ps
module pci_mem_model (
    input  wire logic        clk,
    input  wire logic [1:0]  mode,
    input  wire logic        slow,
    input  wire logic        frame_n_in,
    input  wire logic        irdy_n_in,
    input  wire logic [31:0] ad_in,
    input  wire logic [3:0]  cbe_n_in,
    output logic             p_dev,
    output logic             p_trdy,
    output logic             p_stop,
    output logic             p_oe,
    output logic [31:0]      p_ad
);
    logic [31:0] mem [64];
    logic [31:0] addr = 0;
    logic [3:0]  cmd = 0;
    logic        act = 0, fq = 1, wt = 0, took = 0;
    int          nburst = 0;
    // Mode 1 disconnects, 2 aborts, 3 ignores the address
    assign p_dev  = !(act && mode != 2'h2);
    assign p_stop = !(act && ^mode);
    assign p_trdy = !(act && !irdy_n_in && mode < 2'h2 && !(slow && wt) && !(mode[0] && took));
    assign p_oe   = act && !cmd[0];
    assign p_ad   = ~addr;
    always @(posedge clk) begin
        fq <= frame_n_in;
        wt <= !wt;
        if (fq && !frame_n_in && mode != 2'h3) begin
            act <= 1;
            addr <= ad_in;
            cmd <= cbe_n_in;
            took <= 0;
            nburst <= nburst + 1;
        end else if (act) begin
            if (!irdy_n_in && !p_trdy) begin
                if (cmd[0]) mem[addr[7:2]] <= ad_in;
                addr <= addr + 32'h4;
                took <= 1;
            end
            if (frame_n_in && (irdy_n_in || !p_trdy || !p_stop)) act <= 0;
        end
    end
endmodule : pci_mem_model

// File: verification/tb.sv
// Self-checking bench for the PCI cycle controller
`timescale 1ns/1ps
module tb;
    import pci_cycle_pkg::*;
    logic clk = 0, rst = 1, b_frame = 1, b_irdy = 1, b_bad = 0, par_q = 0, gnt_n = 1, slow = 0;
    logic hit_cfg = 0, hit_csr = 0, hit_flash = 0, eeprom_load_done = 0, mwi_ok = 0;
    logic mreq_valid = 0, rd_ready = 0, tgt_ready = 1;
    logic [1:0] mode = 2'h3;
    logic [3:0] b_cbe = 4'hf;
    logic [15:0] cmd_reg = 16'h0040, status_clr = 0, mreq_words = 0, tx_max_bytes = 0;
    logic [15:0] rx_max_bytes = 0;
    logic [31:0] b_ad = 0, wr_data = 32'h100, rd_exp = 0;
    logic [7:0] lat_timer = 8'h20;
    job_kind_t mreq_kind = KIND_TX_RD;
    int errors = 0, n_tests = 0;
    logic req_n, frame_n_out, irdy_n_out, m_ctl_oe_n, trdy_n_out, stop_n_out, devsel_n_out;
    logic t_ctl_oe_n, ad_oe_n, par_out, par_oe_n, perr_n_out, perr_oe_n, serr_oe_n;
    logic mreq_ready, wr_ready, rd_valid, mdone, mdone_perr, p_dev, p_trdy, p_stop, p_oe;
    logic [1:0] mdone_code;
    logic [3:0] cbe_n_out;
    logic [15:0] status;
    logic [31:0] ad_out, rd_data, p_ad, tgt_wdata;
    wire frame_n_in = (m_ctl_oe_n | frame_n_out) & b_frame;
    wire irdy_n_in = (m_ctl_oe_n | irdy_n_out) & b_irdy;
    wire trdy_n_in = (t_ctl_oe_n | trdy_n_out) & p_trdy;
    wire stop_n_in = (t_ctl_oe_n | stop_n_out) & p_stop;
    wire devsel_n_in = (t_ctl_oe_n | devsel_n_out) & p_dev;
    wire [3:0] cbe_n_in = m_ctl_oe_n ? b_cbe : cbe_n_out;
    wire [31:0] ad_in = !ad_oe_n ? ad_out : p_oe ? p_ad : b_ad;
    wire par_in = par_oe_n ? par_q : par_out;
    wire [31:0] tgt_rdata = tgt_wdata;
    always #2 clk = ~clk;
    always @(posedge clk) begin
        par_q <= ^{ad_in, cbe_n_in} ^ b_bad;
        gnt_n <= #1 req_n;
        rd_ready <= #1 !rd_ready;
        if (wr_ready) wr_data <= #1 wr_data + 1;
    end
    always @(posedge clk) begin
        if (rd_valid && rd_ready) begin
            check("rd", rd_data, ~rd_exp);
            rd_exp <= rd_exp + 32'h4;
        end
    end
    pci_cycle_ctrl dut (.*, .serr_n_out(), .tgt_addr(), .tgt_cmd(), .tgt_access(),
        .mreq_addr(32'h80), .tx_space_words(16'h40),
        .rx_avail_words(16'h40));
    pci_mem_model pm (.*);
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s exp %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic tcyc(input logic [2:0] hit, input logic [1:0] bad, output logic [1:0] got);
        int i;
        status_clr = 16'hffff;
        @(posedge clk);
        #1;
        status_clr = 0;
        {hit_cfg, hit_csr, hit_flash} = hit;
        b_frame = 0;
        b_cbe = hit[2] ? 4'hb : 4'h7;
        b_ad = 32'h40;
        b_bad = bad[1];
        @(posedge clk);
        #1;
        {hit_cfg, hit_csr, hit_flash} = 3'h0;
        {b_frame, b_irdy, b_cbe, b_ad, b_bad} = {2'b10, 4'h0, 32'h5a, bad[0]};
        for (i = 0; i < 12 && trdy_n_in && stop_n_in; i++) @(posedge clk) #1;
        got = {!stop_n_in, !trdy_n_in};
        @(posedge clk);
        #1;
        {b_irdy, b_bad} = 2'b10;
        repeat (4) @(posedge clk);
        #1;
    endtask : tcyc
    task automatic run(input job_kind_t k, input int w, m, nb, input logic [1:0] code);
        int i, nb0;
        logic [31:0] w0;
        nb0 = pm.nburst;
        w0 = wr_data;
        rd_exp = 32'h80;
        {mode, mreq_kind, mreq_words, mreq_valid} = {m[1:0], k, w[15:0], 1'b1};
        @(posedge clk);
        #1;
        mreq_valid = 0;
        for (i = 0; i < 999 && !mdone; i++) @(posedge clk) #1;
        check("done", {mdone, mdone_code}, {1'b1, code});
        check("bursts", pm.nburst - nb0, nb);
        if (k[1] && code == DONE_OK) for (i = 0; i < w; i++) check("mem", pm.mem[32+i], w0 + i);
        repeat (4) @(posedge clk);
        #1;
    endtask : run
    task automatic print_verdict();
        $display("checks %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : print_verdict
    initial begin
        #100000;
        errors++;
        print_verdict();
    end
    initial begin
        logic [1:0] got;
        static logic [3:0] cmds [4] = '{CMD_MEM_RD_MULT, CMD_MEM_RD_LINE, CMD_MEM_WR, CMD_MEM_WR};
        repeat (16) @(posedge clk);
        #1;
        rst = 0;
        tcyc(3'h4, 2'h0, got);
        check("retry", got, 2'h2);
        eeprom_load_done = 1;
        tcyc(3'h4, 2'h0, got);
        check("cfg", got, 2'h3);
        check("wdata", tgt_wdata, 32'h5a);
        tcyc(3'h2, 2'h1, got);
        check("dpar", {got, status[15]}, 3'h7);
        cmd_reg = 16'h0140;
        tcyc(3'h0, 2'h2, got);
        check("apar", status[15:14], 2'h3);
        cmd_reg = 16'h0040;
        tcyc(3'h1, 2'h2, got);
        check("claim", {got, status[15:14]}, 4'he);
        for (int i = 0; i < 4; i++) begin
            run(job_kind_t'(i), 1, 0, 1, DONE_OK);
            check("cmd", pm.cmd, cmds[i]);
        end
        tx_max_bytes = 16'h4;
        run(KIND_TX_RD, 4, 0, 4, DONE_OK);
        {tx_max_bytes, rx_max_bytes, slow, mwi_ok} = {16'h0, 16'h8, 2'b11};
        run(KIND_RX_WR, 4, 0, 2, DONE_OK);
        check("mwi", pm.cmd, CMD_MEM_WR_INV);
        {rx_max_bytes, slow, mwi_ok, lat_timer} = {16'h0, 2'b00, 8'h2};
        run(KIND_CTRL_WR, 8, 0, 2, DONE_OK);
        lat_timer = 8'h20;
        run(KIND_CTRL_WR, 3, 1, 3, DONE_OK);
        run(KIND_CTRL_WR, 2, 2, 1, DONE_TABORT);
        check("tabort", status[12], 1);
        run(KIND_RX_WR, 2, 3, 0, DONE_MABORT);
        status_clr = 16'hffff;
        @(posedge clk);
        #1;
        {status_clr, b_bad} = {16'h0, 1'b1};
        run(KIND_CTRL_RD, 1, 0, 1, DONE_OK);
        b_bad = 0;
        check("mperr", {mdone_perr, status[15], status[8]}, 3'h7);
        print_verdict();
    end
endmodule : tb
